// ===== rtl/fli_device.sv
/*
  Driver device end: I2C slave at the fixed address, register file,
  mode decode, multi-function pin and flash trigger/override logic.
  Assumes SCL and SDA are asynchronous and slow against CLK_SYS.
*/
// Operation
// - SDA changes only while SCL is low
// - SDA falling with SCL high starts session
// - SDA rising with SCL high ends session
// - Eight bits MSB first, then ack slot
// - Device pulls SDA low on ninth clock
// - Master clocks ack and releases SDA
// - Address 53h plus direction bit
// - Write: register byte then data byte
// - Mode bits plus boost bit select function
// - Indicator: only sink one, fixed 20mA
// - Boost with mode 00: sinks off
// - Nonzero mode overrides boost bit
// - Feedback bit: 0 450mV, 1 350mV
// - Reset select: 0 hardware reset, 1 GPIO
// - Direction bit: 0 input, 1 output
// - Input pin level copied on each write
// - Master releases reset, then selects output
// - Data bit drives or holds pin level
// - Overvoltage bit: 0 low, 1 high
// - Current limit: 0 2.5A, 1 1.7A
// - Trigger pin flashes until release or timeout
// - Override pin drops flash to torch level
`timescale 1ns/100ps
`default_nettype none
module fli_device
  import fli_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RST_B,
  // Link
  fli_if.dev              LINK,
  // Pins
  input  wire logic       FLASH_TRIGGER_PIN,
  input  wire logic       TORCH_OVERRIDE_PIN,
  input  wire logic       MF_PIN_IN,
  output logic            MF_PIN_OUT,
  output logic            MF_PIN_OE,
  // Analog controls
  output fli_pkg::fli_fn_e FUNC,
  output logic            LED_SINK_ONE,
  output logic            LED_SINK_TWO,
  output logic            IND_FIXED_20MA,
  output logic [6:0]      LED_LEVEL,
  output logic            FEEDBACK_LEVEL_SEL,
  output logic            OVERVOLTAGE_LEVEL_SEL,
  output logic            INDUCTOR_LIMIT_SEL,
  output logic [1:0]      RAMP_STEP,
  output logic            FLASH_ACTIVE
);
  import fli_pkg::*;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_ADDR = 6'h02, S_REG = 6'h04,
    S_WDAT = 6'h08, S_RDAT = 6'h10, S_ACK = 6'h20
  } fli_dst_e;

  // ==========================================================================
  // Synchronisers
  logic [1:0] scl_s_r, sda_s_r, fen_s_r, tx_s_r, mf_s_r;
  logic       scl_d_r, sda_d_r;
  always_ff @(posedge CLK_SYS) begin
    scl_s_r <= {scl_s_r[0], LINK.scl};
    sda_s_r <= {sda_s_r[0], LINK.sda};
    fen_s_r <= {fen_s_r[0], FLASH_TRIGGER_PIN};
    tx_s_r  <= {tx_s_r[0], TORCH_OVERRIDE_PIN};
    mf_s_r  <= {mf_s_r[0], MF_PIN_IN};
    scl_d_r <= scl_s_r[1];
    sda_d_r <= sda_s_r[1];
  end
  wire scl_rise = scl_s_r[1] & ~scl_d_r;
  wire scl_fall = ~scl_s_r[1] & scl_d_r;
  wire start_ev = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
  wire stop_ev  = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

  // ==========================================================================
  // Hardware reset from the multi-function pin while reset select is clear
  logic [7:0] mfp_r;
  wire hw_rst = ~mf_s_r[1] & ~mfp_r[FLI_MFP_RSTSEL];
  wire rst    = ~RST_B | hw_rst;

  // ==========================================================================
  // Slave state machine
  fli_dst_e   st_r, ret_r;
  logic [7:0] sh_r, ptr_r;
  logic [3:0] bit_r;
  logic       rd_r, ack_drv_r, nack_r, wr_stb_r;
  logic [7:0] wr_data_r, rd_byte;
  always_ff @(posedge CLK_SYS) begin
    wr_stb_r <= 1'b0;
    if (rst) begin
      st_r <= S_IDLE; ret_r <= S_IDLE; sh_r <= 8'h00; ptr_r <= 8'h00;
      bit_r <= 4'h0; rd_r <= 1'b0; ack_drv_r <= 1'b0; nack_r <= 1'b0;
      wr_data_r <= 8'h00;
    end else if (start_ev) begin
      st_r <= S_ADDR; bit_r <= 4'h0; ack_drv_r <= 1'b0;
    end else if (stop_ev) begin
      st_r <= S_IDLE; ack_drv_r <= 1'b0;
    end else begin
      case (st_r)
        S_IDLE: ;
        S_ADDR, S_REG, S_WDAT: if (scl_rise) begin
          sh_r  <= {sh_r[6:0], sda_s_r[1]};
          bit_r <= bit_r + 4'h1;
        end else if (scl_fall && bit_r == 4'h8) begin
          bit_r <= 4'h0;
          if (st_r == S_ADDR) begin
            if (sh_r[7:1] == FLI_DEV_ADDR) begin
              rd_r <= sh_r[0]; ack_drv_r <= 1'b1; st_r <= S_ACK;
              ret_r <= sh_r[0] ? S_RDAT : S_REG;
            end else st_r <= S_IDLE;
          end else if (st_r == S_REG) begin
            ptr_r <= sh_r; ack_drv_r <= 1'b1;
            st_r <= S_ACK; ret_r <= S_WDAT;
          end else begin
            wr_data_r <= sh_r; wr_stb_r <= 1'b1;
            ack_drv_r <= 1'b1; st_r <= S_ACK; ret_r <= S_WDAT;
          end
        end
        S_ACK: if (scl_fall) begin
          ack_drv_r <= 1'b0;
          st_r <= ret_r; bit_r <= 4'h0; sh_r <= rd_byte;
        end
        S_RDAT: if (scl_fall) begin
          if (bit_r == 4'h8) st_r <= S_IDLE;
          else begin
            bit_r <= bit_r + 4'h1;
            sh_r  <= {sh_r[6:0], 1'b1};
          end
        end else if (scl_rise && bit_r == 4'h8) nack_r <= sda_s_r[1];
        default: st_r <= S_IDLE;
      endcase
    end
  end
  // Ack and read bits change only after SCL falls
  assign LINK.sda_oe_dev = ack_drv_r |
                           (st_r == S_RDAT && bit_r < 4'h8 && !sh_r[7]);

  // ==========================================================================
  // Register file
  logic [7:0] gen_r, step_r, torch_r, flash_r, tout_r;
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    case (a)
      FLI_REG_GEN:   rd_mux = gen_r;
      FLI_REG_MFP:   rd_mux = mfp_r;
      FLI_REG_STEP:  rd_mux = step_r;
      FLI_REG_TORCH: rd_mux = torch_r;
      FLI_REG_FLASH: rd_mux = flash_r;
      FLI_REG_TOUT:  rd_mux = tout_r;
      default:       rd_mux = 8'h00;
    endcase
  endfunction
  assign rd_byte = rd_mux(ptr_r);

  always_ff @(posedge CLK_SYS) begin
    if (~RST_B | hw_rst) begin
      gen_r <= FLI_RST_GEN; step_r <= FLI_RST_STEP; torch_r <= FLI_RST_TORCH;
      flash_r <= FLI_RST_FLASH; tout_r <= FLI_RST_TOUT;
    end else if (wr_stb_r) begin
      case (ptr_r)
        FLI_REG_GEN:   gen_r   <= (wr_data_r & 8'h27) | FLI_FIX_GEN;
        FLI_REG_STEP:  step_r  <= wr_data_r | FLI_FIX_STEP;
        FLI_REG_TORCH: torch_r <= wr_data_r | FLI_FIX_TORCH;
        FLI_REG_FLASH: flash_r <= wr_data_r | FLI_FIX_FLASH;
        FLI_REG_TOUT:  tout_r  <= wr_data_r | FLI_FIX_TOUT;
        default: ;
      endcase
    end
  end
  // Hardware reset from the pin clears the options as well
  always_ff @(posedge CLK_SYS) begin
    if (~RST_B) mfp_r <= FLI_RST_MFP;
    else if (hw_rst) mfp_r <= FLI_RST_MFP;
    else if (wr_stb_r) begin
      if (ptr_r == FLI_REG_MFP) begin
        mfp_r <= wr_data_r | FLI_FIX_MFP;
        if (!wr_data_r[FLI_MFP_DIR]) mfp_r[FLI_MFP_DATA] <= mf_s_r[1];
      end else if (!mfp_r[FLI_MFP_DIR]) mfp_r[FLI_MFP_DATA] <= mf_s_r[1];
    end
  end
  // Pin driven only in output mode with reset released
  assign MF_PIN_OE  = mfp_r[FLI_MFP_RSTSEL] & mfp_r[FLI_MFP_DIR];
  assign MF_PIN_OUT = mfp_r[FLI_MFP_DATA];

  // ==========================================================================
  // Flash safety timer, unit counts scaled by the timeout code
  logic [31:0] tcnt_r;
  logic        fen_d_r, tout_hit_r;
  wire [31:0] tlimit = (tout_r[3:0] == 4'hF) ? 32'd32 * FLI_TOUT_UNIT_CYC * 10
                     : (tout_r[3:0] == 4'h0) ? 32'd5 * FLI_TOUT_UNIT_CYC
                     : 32'(tout_r[3:0]) * 32'd10 * FLI_TOUT_UNIT_CYC;
  always_ff @(posedge CLK_SYS) begin
    if (rst) begin
      fen_d_r <= 1'b0; tcnt_r <= 32'h0; tout_hit_r <= 1'b0;
    end else begin
      fen_d_r <= fen_s_r[1];
      if (!fen_s_r[1]) begin tcnt_r <= 32'h0; tout_hit_r <= 1'b0; end
      else if (tcnt_r >= tlimit) tout_hit_r <= 1'b1;
      else tcnt_r <= tcnt_r + 32'h1;
    end
  end
  wire ext_flash = fen_s_r[1] & ~tout_hit_r;

  // ==========================================================================
  // Function decode and outputs
  wire [1:0] mode = gen_r[FLI_GEN_MODE_HI:FLI_GEN_MODE_LO];
  fli_fn_e fn;
  always_comb begin
    if (ext_flash) fn = tx_s_r[1] ? FLI_FN_TORCH : FLI_FN_FLASH;
    else if (mode == 2'b11) fn = tx_s_r[1] ? FLI_FN_TORCH : FLI_FN_FLASH;
    else if (mode == 2'b10) fn = FLI_FN_TORCH;
    else if (mode == 2'b01) fn = FLI_FN_IND;
    else fn = gen_r[FLI_GEN_BOOST] ? FLI_FN_VOLT : FLI_FN_OFF;
  end
  always_ff @(posedge CLK_SYS) begin
    if (rst) begin
      FUNC <= FLI_FN_OFF; LED_SINK_ONE <= 1'b0; LED_SINK_TWO <= 1'b0;
      IND_FIXED_20MA <= 1'b0; LED_LEVEL <= 7'h00; FLASH_ACTIVE <= 1'b0;
    end else begin
      FUNC           <= fn;
      LED_SINK_ONE   <= fn inside {FLI_FN_IND, FLI_FN_TORCH, FLI_FN_FLASH};
      LED_SINK_TWO   <= fn inside {FLI_FN_TORCH, FLI_FN_FLASH};
      IND_FIXED_20MA <= (fn == FLI_FN_IND);
      LED_LEVEL      <= (fn == FLI_FN_FLASH) ? flash_r[6:0] : {2'b00, torch_r[4:0]};
      FLASH_ACTIVE   <= (fn == FLI_FN_FLASH);
    end
  end
  assign FEEDBACK_LEVEL_SEL    = gen_r[FLI_GEN_FB_SEL];
  assign OVERVOLTAGE_LEVEL_SEL = mfp_r[FLI_MFP_OVP];
  assign INDUCTOR_LIMIT_SEL    = mfp_r[FLI_MFP_OCL];
  assign RAMP_STEP             = step_r[1:0];
endmodule // fli_device
`default_nettype wire

// ===== include/fli_pkg.sv
/*
  Shared constants for the flash LED driver I2C control link: bus address,
  register map, reset values, field positions and timing counts.
  Assumes both ends run on a 250 MHz system clock.
*/
`default_nettype none
package fli_pkg;
  // ==========================================================================
  // Bus address and register map
  localparam logic [6:0] FLI_DEV_ADDR   = 7'h53;
  localparam logic [7:0] FLI_REG_GEN    = 8'h10;
  localparam logic [7:0] FLI_REG_MFP    = 8'h20;
  localparam logic [7:0] FLI_REG_STEP   = 8'h50;
  localparam logic [7:0] FLI_REG_TORCH  = 8'hA0;
  localparam logic [7:0] FLI_REG_FLASH  = 8'hB0;
  localparam logic [7:0] FLI_REG_TOUT   = 8'hC0;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] FLI_RST_GEN    = 8'h18;
  localparam logic [7:0] FLI_RST_MFP    = 8'hE0;
  localparam logic [7:0] FLI_RST_STEP   = 8'hFC;
  localparam logic [7:0] FLI_RST_TORCH  = 8'h80;
  localparam logic [7:0] FLI_RST_FLASH  = 8'h80;
  localparam logic [7:0] FLI_RST_TOUT   = 8'hF0;
  // Fixed bits that always read back as one
  localparam logic [7:0] FLI_FIX_GEN    = 8'h18;
  localparam logic [7:0] FLI_FIX_MFP    = 8'hE0;
  localparam logic [7:0] FLI_FIX_STEP   = 8'hFC;
  localparam logic [7:0] FLI_FIX_TORCH  = 8'h80;
  localparam logic [7:0] FLI_FIX_FLASH  = 8'h80;
  localparam logic [7:0] FLI_FIX_TOUT   = 8'hF0;
  // ==========================================================================
  // Field positions
  localparam int FLI_GEN_MODE_LO  = 0;
  localparam int FLI_GEN_MODE_HI  = 1;
  localparam int FLI_GEN_BOOST    = 2;
  localparam int FLI_GEN_FB_SEL   = 5;
  localparam int FLI_MFP_RSTSEL   = 0;
  localparam int FLI_MFP_DIR      = 1;
  localparam int FLI_MFP_DATA     = 2;
  localparam int FLI_MFP_OVP      = 3;
  localparam int FLI_MFP_OCL      = 4;
  // ==========================================================================
  // Controller command registers (host side)
  localparam logic [3:0] FLI_HREG_CMD    = 4'h0;
  localparam logic [3:0] FLI_HREG_STATUS = 4'h1;
  localparam logic [3:0] FLI_HREG_RDATA  = 4'h2;
  localparam int         FLI_CMD_GO      = 16;
  localparam int         FLI_CMD_READ    = 17;
  // ==========================================================================
  // Timing
  localparam int FLI_CLK_MHZ      = 250;
  localparam int FLI_SCL_HALF_NS  = 1000;
  localparam int FLI_SCL_HALF_CYC = FLI_SCL_HALF_NS * FLI_CLK_MHZ / 1000;
  localparam int FLI_TOUT_UNIT_US = 10000;
  localparam int FLI_TOUT_UNIT_CYC = FLI_TOUT_UNIT_US * FLI_CLK_MHZ;
  // ==========================================================================
  // Driver function
  typedef enum logic [2:0] {
    FLI_FN_OFF   = 3'h0,
    FLI_FN_IND   = 3'h1,
    FLI_FN_TORCH = 3'h2,
    FLI_FN_FLASH = 3'h3,
    FLI_FN_VOLT  = 3'h4
  } fli_fn_e;
endpackage
`default_nettype wire

// ===== include/fli_if.sv
/*
  Two-wire link between the controller and the driver device.
  Open-drain wires are resolved here from the enables: SDA from both ends, SCL from the host alone;
  the pull-ups implied by the wired-AND are modelled here as well.
*/
`timescale 1ns/100ps
`default_nettype none
interface fli_if;
  logic scl_oe_host;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic scl;
  logic sda;
  // Wired-AND of the open-drain drivers
  assign scl = ~scl_oe_host;
  assign sda = ~(sda_oe_host | sda_oe_dev);
  modport host (output scl_oe_host, output sda_oe_host, input scl, input sda);
  modport dev  (output sda_oe_dev, input scl, input sda);
endinterface
`default_nettype wire

// ===== rtl/fli_host.sv
/*
  Controller end: I2C master that runs one register write or one
  register read (address write, repeated start, one byte) per command.
  Assumes a single master on the link and software on a plain port.
*/
`timescale 1ns/100ps
`default_nettype none
module fli_host
  import fli_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RST_B,
  // Software port
  input  wire logic [3:0] ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic [31:0]     RDATA,
  // Link
  fli_if.host             LINK
);
  import fli_pkg::*;

  typedef enum logic [6:0] {
    H_IDLE = 7'h01, H_START = 7'h02, H_BIT = 7'h04, H_ACK = 7'h08,
    H_RSTA = 7'h10, H_STOP = 7'h20, H_DONE = 7'h40
  } fli_hst_e;

  // ==========================================================================
  // SDA sampled through two flops before use
  logic [1:0] sda_s_r;
  always_ff @(posedge CLK_SYS) sda_s_r <= {sda_s_r[0], LINK.sda};

  fli_hst_e   st_r;
  logic [15:0] tick_r;
  logic [1:0]  ph_r;
  logic [3:0]  bit_r;
  logic [1:0]  byte_r;
  logic [7:0]  sh_r, rx_r, regad_r, wdat_r;
  logic        read_r, busy_r, nack_r, scl_oe_r, sda_oe_r, restarted_r;
  wire tick = (tick_r == 16'(FLI_SCL_HALF_CYC - 1));
  // Mid-point of a half period, where SDA may move while SCL is low
  wire mid  = (tick_r == 16'(FLI_SCL_HALF_CYC / 2 - 1));

  // ==========================================================================
  // Half-period timer for the divided SCL
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B || st_r == H_IDLE || tick) tick_r <= 16'h0;
    else tick_r <= tick_r + 16'h1;
  end

  // Byte to send for each position in the frame
  function automatic logic [7:0] tx_byte(input logic [1:0] n, input logic rs);
    if (n == 2'd0) tx_byte = {FLI_DEV_ADDR, rs};
    else if (n == 2'd1) tx_byte = regad_r;
    else tx_byte = wdat_r;
  endfunction

  // ==========================================================================
  // Master sequencer; in bit and ack states phase 0 SCL low, 1 SCL high
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      st_r <= H_IDLE; ph_r <= 2'd0; bit_r <= 4'h0; byte_r <= 2'd0;
      sh_r <= 8'h00; rx_r <= 8'h00; regad_r <= 8'h00; wdat_r <= 8'h00;
      read_r <= 1'b0; busy_r <= 1'b0; nack_r <= 1'b0;
      scl_oe_r <= 1'b0; sda_oe_r <= 1'b0; restarted_r <= 1'b0;
    end else begin
      case (st_r)
        H_IDLE: if (WR && ADDR == FLI_HREG_CMD && WDATA[FLI_CMD_GO]) begin
          regad_r <= WDATA[15:8]; wdat_r <= WDATA[7:0];
          read_r <= WDATA[FLI_CMD_READ]; busy_r <= 1'b1; nack_r <= 1'b0;
          restarted_r <= 1'b0; byte_r <= 2'd0;
          st_r <= H_START; sda_oe_r <= 1'b1;           // SDA falls, SCL high
        end
        H_START: if (tick) begin
          scl_oe_r <= 1'b1; st_r <= H_BIT; bit_r <= 4'h0; ph_r <= 2'd0;
          sh_r <= tx_byte(byte_r, restarted_r);
        end
        H_BIT: if (tick) begin
          if (ph_r == 2'd0) begin
            // Clock released a quarter period after the data settled
            scl_oe_r <= 1'b0; ph_r <= 2'd1;
          end else begin
            rx_r <= {rx_r[6:0], sda_s_r[1]};
            sh_r <= {sh_r[6:0], 1'b0};
            scl_oe_r <= 1'b1; ph_r <= 2'd0;
            if (bit_r == 4'h7) st_r <= H_ACK;
            bit_r <= bit_r + 4'h1;
          end
        end else if (mid && ph_r == 2'd0) begin
          // Data moved mid-way through SCL low, clear of both clock edges
          if (restarted_r && byte_r == 2'd2) sda_oe_r <= 1'b0;
          else sda_oe_r <= ~sh_r[7];
        end
        H_ACK: if (tick) begin
          if (ph_r == 2'd0) begin
            scl_oe_r <= 1'b0; ph_r <= 2'd1;
          end else begin
            scl_oe_r <= 1'b1; ph_r <= 2'd0; bit_r <= 4'h0;
            if (!(restarted_r && byte_r == 2'd2) && sda_s_r[1]) begin
              nack_r <= 1'b1; st_r <= H_STOP;
            end else if (byte_r == 2'd2) st_r <= H_STOP;
            else if (byte_r == 2'd1 && read_r) st_r <= H_RSTA;
            else begin
              // After a repeated start the next byte is the one read back
              byte_r <= restarted_r ? 2'd2 : byte_r + 2'd1;
              st_r <= H_BIT;
              sh_r <= tx_byte(byte_r + 2'd1, 1'b0);
            end
          end
        end else if (mid && ph_r == 2'd0) begin
          // Release SDA for the device, or NACK the read byte
          sda_oe_r <= 1'b0;
        end
        H_RSTA: if (tick) begin
          // Low: free SDA; high: raise SCL; then SDA falls
          if (ph_r == 2'd0) begin sda_oe_r <= 1'b0; ph_r <= 2'd1; end
          else if (ph_r == 2'd1) begin scl_oe_r <= 1'b0; ph_r <= 2'd2; end
          else begin
            sda_oe_r <= 1'b1; restarted_r <= 1'b1; byte_r <= 2'd0;
            st_r <= H_START; ph_r <= 2'd0;
          end
        end
        H_STOP: if (tick) begin
          if (ph_r == 2'd0) begin sda_oe_r <= 1'b1; ph_r <= 2'd1; end
          else if (ph_r == 2'd1) begin scl_oe_r <= 1'b0; ph_r <= 2'd2; end
          else begin sda_oe_r <= 1'b0; st_r <= H_DONE; ph_r <= 2'd0; end
        end
        H_DONE: if (tick) begin busy_r <= 1'b0; st_r <= H_IDLE; end
        default: st_r <= H_IDLE;
      endcase
    end
  end
  assign LINK.scl_oe_host = scl_oe_r;
  assign LINK.sda_oe_host = sda_oe_r;

  // ==========================================================================
  // Register read port, data one cycle after the strobe
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) RDATA <= 32'h0;
    else if (RD) begin
      case (ADDR)
        FLI_HREG_STATUS: RDATA <= {30'h0, nack_r, busy_r};
        FLI_HREG_RDATA:  RDATA <= {24'h0, rx_r};
        default:         RDATA <= 32'h0;
      endcase
    end else RDATA <= 32'h0;
  end
endmodule // fli_host
`default_nettype wire

// ===== tb/fli_link_assertions.sv
/*
  Concurrent checks on the two-wire link between controller and device.
  Assumes the enables and resolved levels of one link interface.
*/
`timescale 1ns/100ps
`default_nettype none
module fli_link_assertions
  import fli_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Link enables and levels
  input wire logic scl_oe_host,
  input wire logic sda_oe_host,
  input wire logic sda_oe_dev,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // ==========================================================================
  // Bit and byte position since the last start
  logic [3:0] bits_r;
  logic [3:0] bytes_r;
  logic       rw_r;
  logic [6:0] addr_sh_r;
  // Restart on every start, repeated ones too
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B || ($fell(sda) && scl)) begin
      bits_r  <= 4'h0;
      bytes_r <= 4'h0;
    end else if ($rose(scl)) begin
      bits_r  <= (bits_r == 4'h9) ? 4'h1 : bits_r + 4'h1;
      bytes_r <= (bits_r == 4'h9) ? bytes_r + 4'h1 : bytes_r;
    end
  end
  // Address shift and direction bit
  always_ff @(posedge CLK_SYS) begin
    if ($rose(scl)) begin
      addr_sh_r <= {addr_sh_r[5:0], sda};
    end
    if ($rose(scl) && bits_r == 4'h7 && bytes_r == 4'h0) begin
      rw_r <= sda;
    end
  end
  // ==========================================================================
  // Line conditions
  sequence s_start;
    $fell(sda) && scl;
  endsequence
  sequence s_idle;
    (scl && sda)[*8];
  endsequence
  // Ack slot of a byte that the device receives
  wire dev_ack_slot = scl && bits_r == 4'h9 && (bytes_r == 4'h0 || !rw_r);
  AST_DEV_SDA_LOW_PHASE: assert property ($changed(sda_oe_dev) |-> !scl)
    else $error("device moved data while clock high");
  AST_SDA_STABLE_HIGH: assert property (scl && $past(scl) && $changed(sda)
    |-> bits_r == 4'h0 || (bits_r == 4'h1 && bytes_r != 4'h0))
    else $error("data changed in clock high outside start or stop");
  AST_START_HOLD: assert property (s_start |=> (!scl_oe_host)[*8])
    else $error("clock pulled right after start");
  AST_STOP_IDLE: assert property ($rose(sda) && scl |=> s_idle)
    else $error("line not idle after stop");
  AST_STOP_WHOLE_BYTE: assert property ($rose(sda) && scl
    |-> bits_r == 4'h1 && bytes_r != 4'h0)
    else $error("stop inside a byte");
  AST_ACK_DRIVEN: assert property (dev_ack_slot && $past(scl) |-> sda_oe_dev)
    else $error("device missed acknowledge");
  AST_ACK_RELEASED: assert property (scl && $past(scl) && bits_r == 4'h9
    |-> !sda_oe_host)
    else $error("controller held data in ack slot");
  AST_ADDR_VALUE: assert property ($rose(scl) && bits_r == 4'h7 && bytes_r == 4'h0
    |-> addr_sh_r == FLI_DEV_ADDR)
    else $error("wrong device address sent");
endmodule // fli_link_assertions
`default_nettype wire

// ===== tb/tb_top.sv
/*
  Self-checking bench: controller software port, link, device pins.
  Assumes the pull-ups of the link are resolved in the interface.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import fli_pkg::*;
  // ==========================================================================
  // Bench signals
  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic [3:0]  addr    = 4'h0;
  logic [31:0] wdata   = 32'h0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        trig    = 1'b0;
  logic        ovr     = 1'b0;
  logic        mf_in   = 1'b1;
  logic [31:0] rdata;
  logic [6:0]  lvl;
  logic [1:0]  step;
  logic        mf_out, mf_oe, sink1, sink2, ind20, fb_sel, ov_sel, il_sel, flash_act;
  fli_fn_e     func;
  int          num_errors = 0;
  int          checked    = 0;
  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;
  // ==========================================================================
  // Both ends on one link
  fli_if link_if();
  fli_host fli_host_inst (.CLK_SYS(clk_sys), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .LINK(link_if));
  fli_device fli_device_inst (.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(link_if),
    .FLASH_TRIGGER_PIN(trig), .TORCH_OVERRIDE_PIN(ovr), .MF_PIN_IN(mf_in),
    .MF_PIN_OUT(mf_out), .MF_PIN_OE(mf_oe), .FUNC(func), .LED_SINK_ONE(sink1),
    .LED_SINK_TWO(sink2), .IND_FIXED_20MA(ind20), .LED_LEVEL(lvl), .FEEDBACK_LEVEL_SEL(fb_sel),
    .OVERVOLTAGE_LEVEL_SEL(ov_sel), .INDUCTOR_LIMIT_SEL(il_sel), .RAMP_STEP(step),
    .FLASH_ACTIVE(flash_act));
  fli_link_assertions fli_link_assertions_inst (.CLK_SYS(clk_sys), .RST_B(rst_b),
    .scl_oe_host(link_if.scl_oe_host), .sda_oe_host(link_if.sda_oe_host),
    .sda_oe_dev(link_if.sda_oe_dev), .scl(link_if.scl), .sda(link_if.sda));
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sw_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic sw_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // One link command, then poll busy under a bound
  task automatic link_cmd(input logic rd_op, input logic [7:0] r, input logic [7:0] d);
    logic [31:0] st;
    int          n;
    sw_wr(FLI_HREG_CMD, {14'h0, rd_op, 1'b1, r, d});
    st = 32'h1;
    for (n = 0; n < 20000 && st[0] !== 1'b0; n++) sw_rd(FLI_HREG_STATUS, st);
    chk({30'h0, st[1:0]}, 32'h0);
  endtask
  // Pin change, then bounded wait for the function to follow
  task automatic pins(input logic t, input logic o, input fli_fn_e f);
    int i;
    @(posedge clk_sys);
    trig <= t;
    ovr  <= o;
    #1;
    for (i = 0; i < 20 && func !== f; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({29'h0, func}, {29'h0, f});
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] v;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    sw_rd(4'hF, v);
    chk(v, 32'h0);
    chk({29'h0, func}, {29'h0, FLI_FN_OFF});
    chk({28'h0, fb_sel, ov_sel, il_sel, mf_oe}, 32'h0);
    chk({23'h0, lvl, step}, 32'h0);
    $display("Test reset state done");
    link_cmd(1'b0, FLI_REG_GEN, 8'h21);
    chk({29'h0, func}, {29'h0, FLI_FN_IND});
    chk({28'h0, sink1, sink2, ind20, fb_sel}, 32'hB);
    $display("Test indicator write done");
    pins(1'b1, 1'b0, FLI_FN_FLASH);
    chk({31'h0, flash_act}, 32'h1);
    pins(1'b1, 1'b1, FLI_FN_TORCH);
    pins(1'b0, 1'b0, FLI_FN_IND);
    chk({31'h0, flash_act}, 32'h0);
    $display("Test flash pins done");
    link_cmd(1'b1, FLI_REG_GEN, 8'h00);
    sw_rd(FLI_HREG_RDATA, v);
    chk(v, {24'h0, FLI_FIX_GEN | 8'h21});
    $display("Test read back done");
    link_cmd(1'b0, FLI_REG_MFP, 8'h19);
    chk({28'h0, ov_sel, il_sel, mf_oe, mf_out}, 32'hD);
    link_cmd(1'b0, FLI_REG_MFP, 8'h1B);
    chk({28'h0, ov_sel, il_sel, mf_oe, mf_out}, 32'hE);
    $display("Test pin options done");
    print_verdict();
  end
  // Watchdog past the expected run length, inside the cycle budget
  initial begin
    #380000;
    num_errors++;
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
